// ==== design/smi_aggregator_map.svh ====
// Purpose: offsets, field positions, reset values for the SMI status/enable block
// Assumes: printed offsets are register indices; byte address is four times the index
// Notes: included by bare name
//
// How it works
// RQ1: Mouse and keyboard bits of status two mirror their sources and clear only at the source.
// RQ2: The keyboard-controller port bit of status two follows its source and clears at the source.
// RQ3: The infrared bit of status two sets on any transition of the selected infrared input.
// RQ4: A read of status two clears the infrared transition bit.
// RQ5: Status three holds pin events at bits 0-2 and 4-7, bit 3 reserved, each cleared by writing one.
// RQ6: Status four holds eight pin events, cleared by writing one, writing zero does nothing.
// RQ7: Status five holds pin events at bits 0-3 and tach events at bits 6-7, cleared by writing one.
// RQ8: Index 15 hex is read-only and always reads zero.
// RQ9: Enable one gates parallel, serial b, serial a, floppy and MIDI interrupts at bits 1-5.
// RQ10: An enable bit admits its status source to the group signal only when it is one.
// RQ11: Enable two gates mouse, keyboard, infrared and port sources at bits 0, 1, 2 and 4.
// RQ12: Enable two bit 5 routes the group signal into the wake logic.
// RQ13: Enable two bit 6 places the group signal on the serial interrupt stream.
// RQ14: Enable two bit 7 drives the group signal out on the dedicated output pin.
// RQ15: All these registers load zero on the standby power-on reset.
// RQ16: The parallel interrupt status reads one while the port is inactive, else follows acknowledge.
// RQ17: The active-low group signal asserts while any status bit and its enable are both one.
`ifndef SMI_AGGREGATOR_MAP_SVH
`define SMI_AGGREGATOR_MAP_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_STATUS_TWO 6'h11
`define IDX_STATUS_THREE 6'h12
`define IDX_STATUS_FOUR 6'h13
`define IDX_STATUS_FIVE 6'h14
`define IDX_RESERVED_GAP 6'h15
`define IDX_ENABLE_ONE 6'h16
`define IDX_ENABLE_TWO 6'h17
`define IDX_IRQ_STATUS 6'h20
`define IDX_IRQ_MASK 6'h21

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BIT_MOUSE 0
`define BIT_KEYBOARD 1
`define BIT_INFRARED 2
`define BIT_KBC_PORT 4
`define BIT_TO_WAKE 5
`define BIT_TO_SERIAL 6
`define BIT_TO_PIN 7
`define MASK_STATUS_TWO 8'h17
`define MASK_STATUS_THREE 8'hF7
`define MASK_STATUS_FIVE 8'hCF
`define MASK_ENABLE_ONE 8'h3E
`define MASK_GROUP_TWO 8'h17
`define MASK_IRQ 8'h03
`define RESET_ZERO 8'h00

`endif

// ==== design/smi_aggregator_pkg.sv ====
// Purpose: shared types for the SMI status/enable block
// Assumes: nothing
// Notes: constants live in the map header
package smi_aggregator_pkg;
    typedef logic [7:0] byte_reg_t;
    typedef logic [1:0] axi_resp_t;
endpackage : smi_aggregator_pkg

// ==== design/smi_status_enable_aggregator.sv ====
// Purpose: SMI status and enable registers with group SMI routing, AXI4-Lite slave
// Assumes: rst_i is the standby power-on reset; config inputs are on clk_i
// Notes: byte address = 4 * register index; data in low byte
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "smi_aggregator_map.svh"

module smi_status_enable_aggregator (
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Interrupt sources from pins and neighbouring blocks
    input wire logic mouse_irq_i,
    input wire logic keyboard_irq_i,
    input wire logic kbc_port_line_i,
    input wire logic infrared_receive_a_i,
    input wire logic infrared_receive_b_i,
    input wire logic infrared_select_b_i,
    input wire logic parallel_active_i,
    input wire logic printer_acknowledge_i,
    input wire logic serial_b_irq_i,
    input wire logic serial_a_irq_i,
    input wire logic floppy_irq_i,
    input wire logic midi_irq_i,
    input wire logic [6:0] pin_events_three_i,
    input wire logic [7:0] pin_events_four_i,
    input wire logic [3:0] pin_events_five_i,
    input wire logic fan_speed_input_one_i,
    input wire logic fan_speed_input_two_i,
    // Outputs
    output logic group_mgmt_interrupt_n_o,
    output logic mgmt_interrupt_pin_n_o,
    output logic serial_irq_smi_o,
    output logic wake_smi_o,
    output logic irq_o
);

    localparam int SYNC_W = 31;
    localparam smi_aggregator_pkg::axi_resp_t RESP_OKAY = 2'b00;
    localparam smi_aggregator_pkg::axi_resp_t RESP_SLVERR = 2'b10;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_a_reg;
    logic [SYNC_W-1:0] sync_b_reg;
    logic [SYNC_W-1:0] sync_prev_reg;

    // Pins are asynchronous; only stage b and later are looked at
    assign raw_in = {fan_speed_input_two_i, fan_speed_input_one_i, pin_events_five_i,
                     pin_events_four_i, pin_events_three_i, midi_irq_i, floppy_irq_i,
                     serial_a_irq_i, serial_b_irq_i, printer_acknowledge_i,
                     infrared_receive_b_i, infrared_receive_a_i, kbc_port_line_i,
                     keyboard_irq_i, mouse_irq_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a_reg <= '0;
            sync_b_reg <= '0;
            sync_prev_reg <= '0;
        end else begin
            sync_a_reg <= raw_in;
            sync_b_reg <= sync_a_reg;
            sync_prev_reg <= sync_b_reg;
        end
    end

    // Named views of the synchronised sources
    wire mouse_s = sync_b_reg[0];
    wire keyboard_s = sync_b_reg[1];
    wire kbc_port_s = sync_b_reg[2];
    wire ack_s = sync_b_reg[5];
    wire [3:0] legacy_irq_s = sync_b_reg[9:6];
    wire [SYNC_W-1:0] rise = sync_b_reg & ~sync_prev_reg;

    // Infrared edge taken after the receive mux, either direction
    wire ir_now = infrared_select_b_i ? sync_b_reg[4] : sync_b_reg[3];
    wire ir_prev = infrared_select_b_i ? sync_prev_reg[4] : sync_prev_reg[3];
    wire ir_edge = ir_now ^ ir_prev; // [RQ3]

    // Pin and tach events land in their register positions
    wire [7:0] set_three = {rise[16:13], 1'b0, rise[12:10]} & `MASK_STATUS_THREE; // [RQ5]
    wire [7:0] set_four = rise[24:17]; // [RQ6]
    wire [7:0] set_five = {rise[30:29], 2'b00, rise[28:25]} & `MASK_STATUS_FIVE; // [RQ7]

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    smi_aggregator_pkg::byte_reg_t infra_reg;
    smi_aggregator_pkg::byte_reg_t status_three_reg;
    smi_aggregator_pkg::byte_reg_t status_four_reg;
    smi_aggregator_pkg::byte_reg_t status_five_reg;
    smi_aggregator_pkg::byte_reg_t enable_one_reg;
    smi_aggregator_pkg::byte_reg_t enable_two_reg;
    smi_aggregator_pkg::byte_reg_t irq_status_reg;
    smi_aggregator_pkg::byte_reg_t irq_mask_reg;
    logic group_reg;

    // Parallel status: forced high while the port is off
    wire parallel_status = parallel_active_i ? ack_s : 1'b1; // [RQ16]
    wire [7:0] status_one = {2'b00, legacy_irq_s[3], legacy_irq_s[2], legacy_irq_s[1],
                             legacy_irq_s[0], parallel_status, 1'b0};

    // Mirror bits are live, cleared only at their source
    wire [7:0] status_two = {3'b000, kbc_port_s, 1'b0, infra_reg[0], keyboard_s,
                             mouse_s}; // [RQ1] [RQ2]

    // Group request: any status bit with its enable set
    wire hit_one = |(status_one & enable_one_reg & `MASK_ENABLE_ONE); // [RQ9] [RQ10]
    wire hit_two = |(status_two & enable_two_reg & `MASK_GROUP_TWO); // [RQ11] [RQ10]
    wire group_next = hit_one | hit_two; // [RQ17]

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    logic aw_held_reg;
    logic w_held_reg;
    logic [5:0] aw_idx_reg;
    logic [7:0] w_data_reg;
    logic w_lane_reg;
    logic bvalid_reg;
    smi_aggregator_pkg::axi_resp_t bresp_reg;

    // Address and data taken in either order, one write in flight
    assign s_axi_awready_o = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready_o = ~w_held_reg & ~bvalid_reg;
    wire aw_fire = s_axi_awvalid_i & s_axi_awready_o;
    wire w_fire = s_axi_wvalid_i & s_axi_wready_o;
    wire wr_go = aw_held_reg & w_held_reg;
    wire wr_lane = wr_go & w_lane_reg;

    // Write decode
    wire wr_three = wr_lane & (aw_idx_reg == `IDX_STATUS_THREE);
    wire wr_four = wr_lane & (aw_idx_reg == `IDX_STATUS_FOUR);
    wire wr_five = wr_lane & (aw_idx_reg == `IDX_STATUS_FIVE);
    wire wr_en_one = wr_lane & (aw_idx_reg == `IDX_ENABLE_ONE);
    wire wr_en_two = wr_lane & (aw_idx_reg == `IDX_ENABLE_TWO);
    wire wr_irq_st = wr_lane & (aw_idx_reg == `IDX_IRQ_STATUS);
    wire wr_irq_mk = wr_lane & (aw_idx_reg == `IDX_IRQ_MASK);

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx >= `IDX_STATUS_TWO && idx <= `IDX_ENABLE_TWO) ||
                 idx == `IDX_IRQ_STATUS || idx == `IDX_IRQ_MASK;
    endfunction : mapped

    // Write one to clear, a new event in the same cycle wins
    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                       input logic hit, input logic [7:0] data);
        w1c = (cur & ~(hit ? data : 8'h00)) | set;
    endfunction : w1c

    // Capture halves of a write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_idx_reg <= 6'h00;
            w_data_reg <= `RESET_ZERO;
            w_lane_reg <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg <= s_axi_awaddr_i[7:2];
            end else if (wr_go) begin
                aw_held_reg <= 1'b0;
            end
            if (w_fire) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i[7:0];
                w_lane_reg <= s_axi_wstrb_i[0];
            end else if (wr_go) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    logic rvalid_reg;
    logic [7:0] rdata_reg;
    smi_aggregator_pkg::axi_resp_t rresp_reg;

    assign s_axi_arready_o = ~rvalid_reg;
    wire ar_fire = s_axi_arvalid_i & s_axi_arready_o;
    wire [5:0] ar_idx = s_axi_araddr_i[7:2];
    // Read side effect on the infrared bit
    wire rd_status_two = ar_fire & (ar_idx == `IDX_STATUS_TWO); // [RQ4]

    // Read mux; gap index and reserved bits read zero
    wire [7:0] rd_mux =
        (ar_idx == `IDX_STATUS_TWO) ? status_two :
        (ar_idx == `IDX_STATUS_THREE) ? status_three_reg :
        (ar_idx == `IDX_STATUS_FOUR) ? status_four_reg :
        (ar_idx == `IDX_STATUS_FIVE) ? status_five_reg :
        (ar_idx == `IDX_RESERVED_GAP) ? `RESET_ZERO : // [RQ8]
        (ar_idx == `IDX_ENABLE_ONE) ? enable_one_reg :
        (ar_idx == `IDX_ENABLE_TWO) ? enable_two_reg :
        (ar_idx == `IDX_IRQ_STATUS) ? irq_status_reg :
        (ar_idx == `IDX_IRQ_MASK) ? irq_mask_reg : `RESET_ZERO;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= `RESET_ZERO;
            rresp_reg <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign s_axi_rdata_o = {24'h0000_00, rdata_reg};

    // ----------------------------------------
    // Status and enable storage
    // ----------------------------------------
    // Register bit 0 holds the sticky infrared edge; edge wins over the read clear
    wire infra_next = ir_edge | (infra_reg[0] & ~rd_status_two); // [RQ3] [RQ4]

    // Own interrupt events: group assertion and any new pin event
    wire [7:0] irq_set = {6'b00_0000, |(set_three | set_four | set_five),
                          group_next & ~group_reg};

    // Every register starts at zero on the standby reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            infra_reg <= `RESET_ZERO; // [RQ15]
            status_three_reg <= `RESET_ZERO; // [RQ15]
            status_four_reg <= `RESET_ZERO; // [RQ15]
            status_five_reg <= `RESET_ZERO; // [RQ15]
            enable_one_reg <= `RESET_ZERO; // [RQ15]
            enable_two_reg <= `RESET_ZERO; // [RQ15]
            irq_status_reg <= `RESET_ZERO;
            irq_mask_reg <= `RESET_ZERO;
        end else begin
            infra_reg <= {7'b000_0000, infra_next};
            status_three_reg <= w1c(status_three_reg, set_three, wr_three, w_data_reg); // [RQ5]
            status_four_reg <= w1c(status_four_reg, set_four, wr_four, w_data_reg); // [RQ6]
            status_five_reg <= w1c(status_five_reg, set_five, wr_five, w_data_reg); // [RQ7]
            irq_status_reg <= w1c(irq_status_reg, irq_set, wr_irq_st, w_data_reg);
            if (wr_en_one) begin
                enable_one_reg <= w_data_reg & `MASK_ENABLE_ONE; // [RQ9]
            end
            if (wr_en_two) begin
                enable_two_reg <= w_data_reg & 8'hF7; // [RQ11]
            end
            if (wr_irq_mk) begin
                irq_mask_reg <= w_data_reg & `MASK_IRQ;
            end
        end
    end

    // ----------------------------------------
    // Group signal and its routes
    // ----------------------------------------
    // Registered so outputs are glitch-free despite the OR tree
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            group_reg <= 1'b0;
            group_mgmt_interrupt_n_o <= 1'b1;
            mgmt_interrupt_pin_n_o <= 1'b1;
            serial_irq_smi_o <= 1'b0;
            wake_smi_o <= 1'b0;
        end else begin
            group_reg <= group_next;
            group_mgmt_interrupt_n_o <= ~group_next; // [RQ17]
            mgmt_interrupt_pin_n_o <= ~(group_next & enable_two_reg[`BIT_TO_PIN]); // [RQ14]
            serial_irq_smi_o <= group_next & enable_two_reg[`BIT_TO_SERIAL]; // [RQ13]
            wake_smi_o <= group_next & enable_two_reg[`BIT_TO_WAKE]; // [RQ12]
        end
    end

    // Level interrupt while an unmasked sticky bit stands
    assign irq_o = |(irq_status_reg & irq_mask_reg);

endmodule : smi_status_enable_aggregator

// ==== dv/smi_aggregator_assertions.sv ====
// Purpose: port-level checks for the SMI status and enable block
// Assumes: byte address is four times the register index
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`include "smi_aggregator_map.svh"
module smi_aggregator_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic mouse_irq_i,
    input wire logic group_mgmt_interrupt_n_o,
    input wire logic mgmt_interrupt_pin_n_o,
    input wire logic serial_irq_smi_o,
    input wire logic wake_smi_o
);
    logic [5:0] rd_idx_reg;
    logic [2:0] mouse_run_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Index of the read in flight; mouse run length saturates so the check waits past the sync
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_idx_reg <= 6'h00;
            mouse_run_reg <= 3'h0;
        end else begin
            if (s_axi_arvalid_i && s_axi_arready_o) rd_idx_reg <= s_axi_araddr_i[7:2];
            if (!mouse_irq_i) mouse_run_reg <= 3'h0;
            else if (mouse_run_reg != 3'h7) mouse_run_reg <= mouse_run_reg + 3'h1;
        end
    end
    AST_PIN_ROUTE: assert property (!mgmt_interrupt_pin_n_o |-> !group_mgmt_interrupt_n_o)
        else $error("pin asserted without group signal");
    AST_SERIAL_ROUTE: assert property (serial_irq_smi_o |-> !group_mgmt_interrupt_n_o)
        else $error("serial request without group signal");
    AST_WAKE_ROUTE: assert property (wake_smi_o |-> !group_mgmt_interrupt_n_o)
        else $error("wake request without group signal");
    AST_RESET_IDLE: assert property ($fell(rst_i) |-> group_mgmt_interrupt_n_o
        && mgmt_interrupt_pin_n_o && !serial_irq_smi_o && !wake_smi_o)
        else $error("outputs not idle after reset");
    AST_GAP_ZERO: assert property (s_axi_rvalid_o && rd_idx_reg == `IDX_RESERVED_GAP
        |-> s_axi_rdata_o == 32'h0000_0000 && s_axi_rresp_o == 2'b00)
        else $error("reserved gap read not zero");
    AST_STS3_RSVD: assert property (s_axi_rvalid_o && rd_idx_reg == `IDX_STATUS_THREE
        |-> !s_axi_rdata_o[3])
        else $error("status three reserved bit set");
    AST_STS5_RSVD: assert property (s_axi_rvalid_o && rd_idx_reg == `IDX_STATUS_FIVE
        |-> s_axi_rdata_o[5:4] == 2'b00)
        else $error("status five reserved bits set");
    AST_EN1_RSVD: assert property (s_axi_rvalid_o && rd_idx_reg == `IDX_ENABLE_ONE
        |-> !s_axi_rdata_o[0] && s_axi_rdata_o[7:6] == 2'b00)
        else $error("enable one reserved bits set");
    AST_EN2_RSVD: assert property (s_axi_rvalid_o && rd_idx_reg == `IDX_ENABLE_TWO
        |-> !s_axi_rdata_o[3])
        else $error("enable two reserved bit set");
    AST_MOUSE_MIRROR: assert property ($rose(s_axi_rvalid_o) && mouse_run_reg == 3'h7
        && rd_idx_reg == `IDX_STATUS_TWO |-> s_axi_rdata_o[0])
        else $error("mouse status not mirrored");
endmodule : smi_aggregator_assertions

// ==== dv/smi_host_receiver.sv ====
// Purpose: host chipset side that receives the management interrupt pin
// Assumes: pin is active low
// Notes: counts each new assertion so the bench can see routing
`timescale 1ns/1ps
module smi_host_receiver (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mgmt_interrupt_pin_n_i,
    output logic [7:0] smi_count_o
);
    logic pin_n_prev_reg;
    // One request per falling edge; a held level is not counted twice
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_n_prev_reg <= 1'b1;
            smi_count_o <= 8'h00;
        end else begin
            pin_n_prev_reg <= mgmt_interrupt_pin_n_i;
            if (pin_n_prev_reg && !mgmt_interrupt_pin_n_i) smi_count_o <= smi_count_o + 8'h01;
        end
    end
endmodule : smi_host_receiver

// ==== dv/tb_smi_status_enable_aggregator.sv ====
// Purpose: self-checking bench for the SMI status and enable block
// Assumes: slave answers per the hand-over latencies; watchdog bounds every wait
// Notes: read and write responses are noted in a queue and checked by a monitor
`timescale 1ns/1ps
`include "smi_aggregator_map.svh"
module tb_smi_status_enable_aggregator;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] s_axi_awaddr_i = 8'h00;
    logic [7:0] s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
    logic mouse_irq_i = 1'b0, keyboard_irq_i = 1'b0, kbc_port_line_i = 1'b0;
    logic infrared_receive_a_i = 1'b0, infrared_receive_b_i = 1'b0, infrared_select_b_i = 1'b0;
    logic parallel_active_i = 1'b0, printer_acknowledge_i = 1'b0, serial_b_irq_i = 1'b0;
    logic serial_a_irq_i = 1'b0, floppy_irq_i = 1'b0, midi_irq_i = 1'b0;
    logic [6:0] pin_events_three_i = 7'h00;
    logic [7:0] pin_events_four_i = 8'h00;
    logic [3:0] pin_events_five_i = 4'h0;
    logic fan_speed_input_one_i = 1'b0, fan_speed_input_two_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic group_mgmt_interrupt_n_o, mgmt_interrupt_pin_n_o, serial_irq_smi_o, wake_smi_o, irq_o;
    logic [7:0] smi_count, c0;
    logic [31:0] seed = 32'h0000_448A;
    logic [33:0] exp_q[$];
    logic [7:0] w1c_mask [3] = '{`MASK_STATUS_THREE, 8'hFF, `MASK_STATUS_FIVE};
    int n_fail = 0;
    int total_checks = 0;
    smi_status_enable_aggregator smi_status_enable_aggregator_inst (.*);
    smi_host_receiver smi_host_receiver_inst (.clk_i(clk_i), .rst_i(rst_i),
        .mgmt_interrupt_pin_n_i(mgmt_interrupt_pin_n_o), .smi_count_o(smi_count));
    // 50 MHz clock
    always #10 clk_i = !clk_i;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        total_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out();
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
        logic aw_p = 1'b1;
        logic w_p = 1'b1;
        exp_q.push_back({r, 32'h0000_0000});
        s_axi_awaddr_i <= {idx, 2'b00};
        s_axi_wdata_i <= {24'h00_0000, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge clk_i);
            if (aw_p && s_axi_awready_o) begin
                aw_p = 1'b0;
                s_axi_awvalid_i <= 1'b0;
            end
            if (w_p && s_axi_wready_o) begin
                w_p = 1'b0;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        do @(posedge clk_i); while (!s_axi_bvalid_o);
    endtask : wr
    task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
        exp_q.push_back({r, 24'h00_0000, d});
        s_axi_araddr_i <= {idx, 2'b00};
        s_axi_arvalid_i <= 1'b1;
        do @(posedge clk_i); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge clk_i); while (!s_axi_rvalid_o);
    endtask : rd
    // Output order: group_n, pin_n, serial, wake, irq; sampled once settled
    task automatic pins(input logic [4:0] want);
        repeat (4) @(posedge clk_i);
        #1;
        check({29'h0000_0000, group_mgmt_interrupt_n_o, mgmt_interrupt_pin_n_o,
            serial_irq_smi_o, wake_smi_o, irq_o}, {29'h0000_0000, want});
        @(posedge clk_i);
    endtask : pins
    // Each response handshake takes the oldest note
    always @(posedge clk_i) begin
        if (s_axi_rvalid_o && s_axi_rready_i)
            check({s_axi_rresp_o, s_axi_rdata_o}, exp_q.pop_front());
        if (s_axi_bvalid_o && s_axi_bready_i)
            check({s_axi_bresp_o, 32'h0000_0000}, exp_q.pop_front());
    end
    // Watchdog, well past the expected run length
    initial begin
        #400000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 17; i <= 23; i++) rd(6'(i), 8'h00, 2'b00);
        rd(6'h30, 8'h00, 2'b10);
        wr(6'h30, 8'hFF, 2'b10);
        wr(`IDX_RESERVED_GAP, 8'hFF, 2'b00);
        rd(`IDX_RESERVED_GAP, 8'h00, 2'b00);
        seed = xs(seed);
        wr(`IDX_ENABLE_ONE, seed[7:0], 2'b00);
        rd(`IDX_ENABLE_ONE, seed[7:0] & `MASK_ENABLE_ONE, 2'b00);
        wr(`IDX_ENABLE_TWO, seed[15:8], 2'b00);
        rd(`IDX_ENABLE_TWO, seed[15:8] & 8'hF7, 2'b00);
        wr(`IDX_ENABLE_ONE, 8'h00, 2'b00);
        s_axi_wstrb_i <= 4'hE;
        wr(`IDX_ENABLE_ONE, 8'h3E, 2'b00);
        s_axi_wstrb_i <= 4'hF;
        rd(`IDX_ENABLE_ONE, 8'h00, 2'b00);
        wr(`IDX_ENABLE_TWO, 8'h00, 2'b00);
        wr(`IDX_IRQ_STATUS, 8'h03, 2'b00);
        // Level mirrors survive reads and writes, drop with the source
        {mouse_irq_i, keyboard_irq_i, kbc_port_line_i} <= 3'h7;
        repeat (6) @(posedge clk_i);
        rd(`IDX_STATUS_TWO, 8'h13, 2'b00);
        wr(`IDX_STATUS_TWO, 8'h13, 2'b00);
        rd(`IDX_STATUS_TWO, 8'h13, 2'b00);
        {mouse_irq_i, keyboard_irq_i, kbc_port_line_i} <= 3'h0;
        repeat (4) @(posedge clk_i);
        rd(`IDX_STATUS_TWO, 8'h00, 2'b00);
        // Infrared: both edges count, only the selected input, read clears
        for (int k = 0; k < 4; k++) begin
            infrared_select_b_i <= (k > 1);
            if (k == 3) infrared_receive_b_i <= 1'b1;
            else infrared_receive_a_i <= !infrared_receive_a_i;
            repeat (5) @(posedge clk_i);
            rd(`IDX_STATUS_TWO, (k == 2) ? 8'h00 : 8'h04, 2'b00);
            rd(`IDX_STATUS_TWO, 8'h00, 2'b00);
        end
        // Pin and tach events, then random write-one-to-clear masks
        {pin_events_three_i, pin_events_four_i, pin_events_five_i} <= 19'h7_FFFF;
        {fan_speed_input_one_i, fan_speed_input_two_i} <= 2'h3;
        repeat (5) @(posedge clk_i);
        {pin_events_three_i, pin_events_four_i, pin_events_five_i} <= 19'h0_0000;
        {fan_speed_input_one_i, fan_speed_input_two_i} <= 2'h0;
        repeat (5) @(posedge clk_i);
        for (int i = 0; i < 3; i++) begin
            rd(6'(18 + i), w1c_mask[i], 2'b00);
            seed = xs(seed);
            wr(6'(18 + i), seed[7:0], 2'b00);
            rd(6'(18 + i), w1c_mask[i] & ~seed[7:0], 2'b00);
        end
        // Routing of the group signal to pin, serial stream and wake logic
        c0 = smi_count;
        wr(`IDX_ENABLE_TWO, 8'hE1, 2'b00);
        mouse_irq_i <= 1'b1;
        pins(5'b00110);
        check({26'h000_0000, smi_count}, {26'h000_0000, c0 + 8'h01});
        wr(`IDX_ENABLE_TWO, 8'h60, 2'b00);
        pins(5'b11000);
        mouse_irq_i <= 1'b0;
        wr(`IDX_ENABLE_TWO, 8'h80, 2'b00);
        wr(`IDX_ENABLE_ONE, 8'h02, 2'b00);
        pins(5'b00000);
        parallel_active_i <= 1'b1;
        pins(5'b11000);
        printer_acknowledge_i <= 1'b1;
        pins(5'b00000);
        printer_acknowledge_i <= 1'b0;
        for (int b = 2; b < 6; b++) begin
            {midi_irq_i, floppy_irq_i, serial_a_irq_i, serial_b_irq_i} <= 4'h1 << (b - 2);
            wr(`IDX_ENABLE_ONE, 8'h01 << b, 2'b00);
            pins(5'b00000);
            wr(`IDX_ENABLE_ONE, 8'h3C ^ (8'h01 << b), 2'b00);
            pins(5'b11000);
        end
        // Interrupt raised, masked and cleared
        rd(`IDX_IRQ_STATUS, 8'h03, 2'b00);
        wr(`IDX_IRQ_MASK, 8'h03, 2'b00);
        pins(5'b11001);
        wr(`IDX_IRQ_MASK, 8'h00, 2'b00);
        pins(5'b11000);
        wr(`IDX_IRQ_MASK, 8'h03, 2'b00);
        wr(`IDX_IRQ_STATUS, 8'h03, 2'b00);
        pins(5'b11000);
        close_out();
    end
endmodule : tb_smi_status_enable_aggregator
bind smi_status_enable_aggregator smi_aggregator_assertions smi_aggregator_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .mouse_irq_i(mouse_irq_i),
    .group_mgmt_interrupt_n_o(group_mgmt_interrupt_n_o),
    .mgmt_interrupt_pin_n_o(mgmt_interrupt_pin_n_o),
    .serial_irq_smi_o(serial_irq_smi_o), .wake_smi_o(wake_smi_o));
